// ==== hw/eppp_fifo.sv ====
// Shared byte FIFO with tag bit; depth must be a power of two
`timescale 1ns/1ps
module eppp_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input wire logic clock,
	input wire logic nrst,
	eppp_fifo_if.store q
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	wire push = q.push_valid & q.push_ready;
	wire pop = q.pop_valid & q.pop_ready;

	// Honest flags straight from the occupancy count
	assign q.push_ready = cnt_q != (AW+1)'(DEPTH);
	assign q.pop_valid = cnt_q != '0;
	assign q.pop_data = mem_q[rp_q];
	assign q.level = cnt_q;

	// Storage has no reset so it maps onto plain RAM
	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wp_q] <= q.push_data;
		end
	end

	// Pointers wrap naturally at the power-of-two depth
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= wp_q + AW'(push);
			rp_q <= rp_q + AW'(pop);
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	fifo_full_a: assert property (@(posedge clock) disable iff (!nrst)
		(cnt_q == (AW+1)'(DEPTH) && !pop) |=> cnt_q == (AW+1)'(DEPTH))
		else $error("fifo level moved while full");
endmodule

// ==== hw/eppp_fifo_if.sv ====
// Push and pop signals of the shared transfer FIFO
`timescale 1ns/1ps
interface eppp_fifo_if #(
	parameter int W = 9,
	parameter int D = 16
);
	logic push_valid;
	logic push_ready;
	logic [W-1:0] push_data;
	logic pop_valid;
	logic pop_ready;
	logic [W-1:0] pop_data;
	logic [$clog2(D+1)-1:0] level;
	modport store (input push_valid, push_data, pop_ready,
		output push_ready, pop_valid, pop_data, level);
	modport user (output push_valid, push_data, pop_ready,
		input push_ready, pop_valid, pop_data, level);
endinterface

// ==== hw/eppp_pkg.sv ====
// Shared constants for the multi-mode parallel port
package eppp_pkg;
	// Register offsets from the port base address
	localparam logic [10:0] OFF_DATA = 11'h000;
	localparam logic [10:0] OFF_DSR = 11'h001;
	localparam logic [10:0] OFF_DCR = 11'h002;
	localparam logic [10:0] OFF_EPPA = 11'h003;
	localparam logic [10:0] OFF_EPPD = 11'h004;
	localparam logic [10:0] OFF_FIFO = 11'h400;
	localparam logic [10:0] OFF_CFGB = 11'h401;
	localparam logic [10:0] OFF_ECR = 11'h402;
	// Extended control mode field values
	localparam logic [2:0] MODE_SPP = 3'h0;
	localparam logic [2:0] MODE_PS2 = 3'h1;
	localparam logic [2:0] MODE_COMPAT_DATA_FIFO = 3'h2;
	localparam logic [2:0] MODE_ECP = 3'h3;
	localparam logic [2:0] MODE_EPP = 3'h4;
	localparam logic [2:0] MODE_TEST = 3'h6;
	localparam logic [2:0] MODE_CFG = 3'h7;
	// Control register bit positions
	localparam int DCR_STB = 0;
	localparam int DCR_AFD = 1;
	localparam int DCR_INIT = 2;
	localparam int DCR_SLIN = 3;
	localparam int DCR_ACKEN = 4;
	localparam int DCR_DIR = 5;
	// Values after reset
	localparam logic [7:0] DCR_RST = 8'h04;
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic [2:0] ECR_CTL_RST = 3'h0;
	localparam logic [7:0] CFGA_VAL = 8'h10;
	// Synchroniser start value: enable and host strobes at their idle high
	localparam logic [35:0] SYNC_RST = 36'h001e00000;
	// Watchdog: 10 us at the 200 MHz clock
	localparam int CLK_MHZ = 200;
	localparam int EPP_TMO_US = 10;
	localparam int EPP_TMO_CYC = EPP_TMO_US * CLK_MHZ;
	localparam int TMO_W = 12;
	// Shared FIFO shape
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_WIDTH = 9;
endpackage

// ==== hw/eppp_port.sv ====
// Multi-mode parallel port: EPP 1.7 cycles, ECP FIFO paths, RLE expansion
`timescale 1ns/1ps
module eppp_port (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [10:0] host_addr,
	input wire logic host_aen,
	input wire logic host_rd_n,
	input wire logic host_wr_n,
	input wire logic dma_ack_n,
	input wire logic [7:0] host_data_in,
	output logic [7:0] host_data_out,
	output logic host_data_oe,
	output logic host_ready,
	output logic dma_req,
	input wire logic [2:0] cfg_irq_sel,
	input wire logic [2:0] cfg_dma_sel,
	input wire logic [7:0] peripheral_data_in,
	output logic [7:0] peripheral_data_out,
	output logic peripheral_data_oe,
	output logic port_direction_out,
	output logic write_indicator_out,
	output logic data_strobe_out,
	output logic address_strobe_out,
	output logic peripheral_reset_out,
	input wire logic peripheral_wait_in,
	input wire logic peripheral_interrupt_in,
	input wire logic paper_end_in,
	input wire logic select_in,
	input wire logic fault_n_in,
	output logic irq_out
);
	import eppp_pkg::*;

	typedef enum logic [1:0] {E_IDLE, E_ACT, E_ABORT} eppp_epp_t;
	typedef enum logic [1:0] {F_IDLE, F_SETUP, F_STB, F_WAIT} eppp_fwd_t;
	typedef enum logic [1:0] {R_IDLE, R_PUSH, R_ACK} eppp_rev_t;

	logic [35:0] syn;
	eppp_epp_t st_q;
	eppp_fwd_t fs_q;
	eppp_rev_t rs_q;
	logic [7:0] dcr_q, data_q, ewbyte_q, fbyte_q, rbyte_q, hbyte_q;
	logic [2:0] mode_q, ecr_ctl_q;
	logic [TMO_W-1:0] tcnt_q;
	logic [6:0] rle_q, rep_q;
	logic tmo_q, rd_q, wr_q, is_rd_q, use_addr_q, ftag_q, hcmd_q;
	logic rle_pend_q, hwr_pend_q;
	logic [7:0] hdo_q, pdo_q;
	logic hdoe_q, rdy_q, dreq_q, pdoe_q, dir_q, wri_q, dstb_q, astb_q;
	logic prst_q, irq_q;

	eppp_fifo_if #(.W(FIFO_WIDTH), .D(FIFO_DEPTH)) fq ();

	// Every pin input except cfg_irq_sel and cfg_dma_sel crosses two flops before any logic sees it; strobes
	// start idle so the edge detect sees no false access after reset
	eppp_sync #(.W(36), .RST(SYNC_RST)) u_sync (
		.clock(clock),
		.nrst(nrst),
		.d({host_addr, host_aen, host_rd_n, host_wr_n, dma_ack_n,
			host_data_in, peripheral_data_in, peripheral_wait_in,
			peripheral_interrupt_in, paper_end_in, select_in, fault_n_in}),
		.q(syn)
	);

	// One byte store behind every FIFO register
	eppp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock(clock),
		.nrst(nrst),
		.q(fq)
	);

	// Synchronised pin fields
	wire [10:0] addr_s = syn[35:25];
	wire aen_s = syn[24];
	wire rdn_s = syn[23];
	wire wrn_s = syn[22];
	wire dackn_s = syn[21];
	wire [7:0] hdat_s = syn[20:13];
	wire [7:0] pdat_s = syn[12:5];
	wire wait_s = syn[4];
	wire peripheral_interrupt_in_s = syn[3];
	wire pe_s = syn[2];
	wire slct_s = syn[1];
	wire fltn_s = syn[0];

	// Host strobes and their leading edges; DMA acknowledge counts too
	wire cyc_rd = ~rdn_s & (~aen_s | ~dackn_s);
	wire cyc_wr = ~wrn_s & (~aen_s | ~dackn_s);
	wire host_acc = cyc_rd | cyc_wr;
	wire rd_go = cyc_rd & ~rd_q;
	wire wr_go = cyc_wr & ~wr_q;

	// Address decode; status and control ignore the mode field
	wire hit_000 = ~aen_s & (addr_s == OFF_DATA);
	wire hit_dsr = ~aen_s & (addr_s == OFF_DSR);
	wire hit_dcr = ~aen_s & (addr_s == OFF_DCR);
	wire hit_400 = ~aen_s & (addr_s == OFF_FIFO);
	wire hit_401 = ~aen_s & (addr_s == OFF_CFGB);
	wire hit_ecr = ~aen_s & (addr_s == OFF_ECR);
	wire hit_eppa = ~aen_s & (addr_s == OFF_EPPA);
	wire hit_eppd = ~aen_s & (addr_s[10:2] == OFF_EPPD[10:2]);
	wire cfg_mode = mode_q == MODE_CFG;
	wire epp_mode = mode_q == MODE_EPP;
	wire fifo_mode = (mode_q == MODE_COMPAT_DATA_FIFO) | (mode_q == MODE_ECP) |
		(mode_q == MODE_TEST);
	wire hit_fifo = fifo_mode & (hit_400 | ~dackn_s |
		(hit_000 & mode_q == MODE_ECP));
	wire hit_cmd = hit_000 & dackn_s & (mode_q == MODE_ECP);
	wire hit_dat = hit_000 & (mode_q == MODE_SPP | mode_q == MODE_PS2 |
		epp_mode);
	wire epp_hit = epp_mode & (hit_eppa | hit_eppd);
	wire any_hit = hit_000 | hit_dsr | hit_dcr | hit_fifo | hit_ecr |
		epp_hit | (cfg_mode & (hit_400 | hit_401));

	// Engine enables; forward and reverse follow the direction bit
	wire fwd_en = (mode_q == MODE_COMPAT_DATA_FIFO | mode_q == MODE_ECP) &
		~dcr_q[DCR_DIR];
	wire rev_en = (mode_q == MODE_ECP) & dcr_q[DCR_DIR];
	wire epp_act = st_q == E_ACT;
	wire epp_go = epp_hit & (rd_go | wr_go) & (st_q == E_IDLE);
	wire tmo_hit = epp_act & (tcnt_q == TMO_W'(EPP_TMO_CYC - 1));

	// FIFO steering: reverse engine or host fills, forward engine or host drains
	wire fwd_pop = (fs_q == F_IDLE) & ~wait_s;
	assign fq.push_valid = rev_en ? (rs_q == R_PUSH) : hwr_pend_q;
	assign fq.push_data = rev_en ? {1'b0, rbyte_q} : {hcmd_q, hbyte_q};
	assign fq.pop_ready = fwd_en ? fwd_pop : (rd_go & hit_fifo);

	// Readback values; no compression, so bit 7 of config B is zero
	wire [7:0] dsr_v = {~wait_s, peripheral_interrupt_in_s, pe_s, slct_s, fltn_s, 2'b00, tmo_q};
	wire [7:0] cfgb_v = {1'b0, peripheral_interrupt_in_s, cfg_irq_sel, cfg_dma_sel};
	wire [7:0] ecr_v = {mode_q, ecr_ctl_q, ~fq.push_ready, ~fq.pop_valid};
	wire [7:0] fifo_v = fq.pop_valid ? fq.pop_data[7:0] : 8'h00;
	wire [7:0] rd_mux = hit_fifo ? fifo_v :
		(cfg_mode & hit_400) ? CFGA_VAL :
		(cfg_mode & hit_401) ? cfgb_v :
		hit_ecr ? ecr_v :
		hit_dsr ? dsr_v :
		hit_dcr ? dcr_q :
		hit_000 ? (dcr_q[DCR_DIR] ? pdat_s : data_q) : 8'h00;

	// Pin values before their output flops
	wire fstb = ~(fs_q == F_STB);
	wire [7:0] pdo_d = epp_act ? ewbyte_q : fwd_en ? fbyte_q : data_q;
	wire dir_d = dcr_q[DCR_DIR] | (epp_act & is_rd_q) | rev_en;
	wire wri_d = ((mode_q == MODE_COMPAT_DATA_FIFO | mode_q == MODE_ECP) & ~dcr_q[DCR_DIR])
		? fstb : ~((epp_act & ~is_rd_q) | dcr_q[DCR_STB]);
	wire dstb_d = epp_act ? use_addr_q :
		(mode_q == MODE_ECP) ? (rev_en ? (rs_q == R_ACK) : ~ftag_q) :
		~dcr_q[DCR_AFD];
	wire astb_d = epp_act ? ~use_addr_q : ~dcr_q[DCR_SLIN];
	wire rdy_d = ~(epp_act & ~wait_s) & ~hwr_pend_q;
	wire dreq_d = ecr_ctl_q[1] & (fwd_en ? fq.push_ready :
		rev_en & fq.pop_valid);

	// Host strobe history and register writes
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			dcr_q <= DCR_RST;
			data_q <= 8'h00;
			mode_q <= MODE_RST;
			ecr_ctl_q <= ECR_CTL_RST;
		end else begin
			rd_q <= cyc_rd;
			wr_q <= cyc_wr;
			if (wr_go & hit_dcr) begin
				dcr_q <= {2'b00, hdat_s[5:0]};
			end
			if (wr_go & hit_dat) begin
				data_q <= hdat_s;
			end
			if (wr_go & hit_ecr) begin
				mode_q <= hdat_s[7:5];
				ecr_ctl_q <= hdat_s[4:2];
			end
		end
	end

	// Host FIFO writes wait here; ready stays low until space appears
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			hwr_pend_q <= 1'b0;
			hbyte_q <= 8'h00;
			hcmd_q <= 1'b0;
		end else if (wr_go & hit_fifo & ~rev_en & ~hwr_pend_q) begin
			hwr_pend_q <= 1'b1;
			hbyte_q <= hdat_s;
			hcmd_q <= hit_cmd;
		end else if (~rev_en & fq.push_ready) begin
			hwr_pend_q <= 1'b0;
		end
	end

	// EPP 1.7 cycle: strobe follows the host strobe, watchdog ends stalls
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_q <= E_IDLE;
			tcnt_q <= '0;
			is_rd_q <= 1'b0;
			use_addr_q <= 1'b0;
			ewbyte_q <= 8'h00;
		end else begin
			unique case (st_q)
				E_IDLE: begin
					if (epp_go) begin
						st_q <= E_ACT;
						tcnt_q <= '0;
						is_rd_q <= rd_go;
						use_addr_q <= hit_eppa;
						ewbyte_q <= hdat_s;
					end
				end
				E_ACT: begin
					tcnt_q <= tcnt_q + 1'b1;
					if (!host_acc) begin
						st_q <= E_IDLE;
					end else if (tmo_hit) begin
						st_q <= E_ABORT;
					end
				end
				E_ABORT: begin
					if (!host_acc) begin
						st_q <= E_IDLE;
					end
				end
			endcase
		end
	end

	// Timeout flag: reading status clears it, a new timeout wins
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tmo_q <= 1'b0;
		end else if (tmo_hit) begin
			tmo_q <= 1'b1;
		end else if (rd_go & hit_dsr) begin
			tmo_q <= 1'b0;
		end
	end

	// Forward drain: interlocked strobe against busy
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			fs_q <= F_IDLE;
			fbyte_q <= 8'h00;
			ftag_q <= 1'b0;
		end else begin
			unique case (fs_q)
				F_IDLE: begin
					if (fwd_en & fq.pop_valid & fwd_pop) begin
						fbyte_q <= fq.pop_data[7:0];
						ftag_q <= fq.pop_data[8];
						fs_q <= F_SETUP;
					end
				end
				F_SETUP: fs_q <= F_STB;
				F_STB: begin
					if (wait_s) begin
						fs_q <= F_WAIT;
					end
				end
				F_WAIT: begin
					if (!wait_s) begin
						fs_q <= F_IDLE;
					end
				end
			endcase
		end
	end

	// Reverse fill with run-length expansion; count 0..127 repeats
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rs_q <= R_IDLE;
			rbyte_q <= 8'h00;
			rep_q <= 7'h00;
			rle_q <= 7'h00;
			rle_pend_q <= 1'b0;
		end else if (!rev_en) begin
			rs_q <= R_IDLE;
			rle_pend_q <= 1'b0;
		end else begin
			unique case (rs_q)
				R_IDLE: begin
					if (!peripheral_interrupt_in_s && !wait_s) begin
						if (!pdat_s[7]) begin
							rle_q <= pdat_s[6:0];
							rle_pend_q <= 1'b1;
						end
						rs_q <= R_ACK;
					end else if (!peripheral_interrupt_in_s) begin
						rbyte_q <= pdat_s;
						rep_q <= rle_pend_q ? rle_q : 7'h00;
						rle_pend_q <= 1'b0;
						rs_q <= R_PUSH;
					end
				end
				R_PUSH: begin
					if (fq.push_ready) begin
						if (rep_q == 7'h00) begin
							rs_q <= R_ACK;
						end else begin
							rep_q <= rep_q - 1'b1;
						end
					end
				end
				R_ACK: begin
					if (peripheral_interrupt_in_s) begin
						rs_q <= R_IDLE;
					end
				end
			endcase
		end
	end

	// Host read data: latched at the strobe edge, tracks bus in EPP reads
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			hdo_q <= 8'h00;
			hdoe_q <= 1'b0;
		end else begin
			hdoe_q <= cyc_rd & any_hit;
			if (epp_act & is_rd_q) begin
				hdo_q <= pdat_s;
			end else if (rd_go) begin
				hdo_q <= rd_mux;
			end
		end
	end

	// Output flops; strobes idle high, bus released when direction is in
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pdo_q <= 8'h00;
			pdoe_q <= 1'b1;
			dir_q <= 1'b0;
			wri_q <= 1'b1;
			dstb_q <= 1'b1;
			astb_q <= 1'b1;
			rdy_q <= 1'b1;
			dreq_q <= 1'b0;
			prst_q <= DCR_RST[DCR_INIT];
			irq_q <= 1'b0;
		end else begin
			pdo_q <= pdo_d;
			pdoe_q <= ~dir_d;
			dir_q <= dir_d;
			wri_q <= wri_d;
			dstb_q <= dstb_d;
			astb_q <= astb_d;
			rdy_q <= rdy_d;
			dreq_q <= dreq_d;
			prst_q <= dcr_q[DCR_INIT];
			irq_q <= peripheral_interrupt_in_s & dcr_q[DCR_ACKEN];
		end
	end

	assign host_data_out = hdo_q;
	assign host_data_oe = hdoe_q;
	assign host_ready = rdy_q;
	assign dma_req = dreq_q;
	assign peripheral_data_out = pdo_q;
	assign peripheral_data_oe = pdoe_q;
	assign port_direction_out = dir_q;
	assign write_indicator_out = wri_q;
	assign data_strobe_out = dstb_q;
	assign address_strobe_out = astb_q;
	assign peripheral_reset_out = prst_q;
	assign irq_out = irq_q;

	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);

	sequence rle_last_s;
		rev_en && rs_q == R_PUSH && rep_q == 7'h00 && fq.push_ready;
	endsequence

	strobe_on_a: assert property (epp_go |-> ##2
		(!data_strobe_out || !address_strobe_out))
		else $error("no EPP strobe after cycle start");
	rdy_hold_a: assert property ((epp_act && !wait_s) |=> !host_ready)
		else $error("ready not held while peripheral waits");
	wdog_abort_a: assert property (tmo_hit |=> (tmo_q && !epp_act)
		##1 (data_strobe_out && address_strobe_out))
		else $error("watchdog did not abort the cycle");
	stb_release_a: assert property ((epp_act && !host_acc) |=> ##1
		(data_strobe_out && address_strobe_out))
		else $error("strobe held after host strobe ended");
	dir_read_a: assert property ((epp_act && is_rd_q) |=>
		(port_direction_out && !peripheral_data_oe))
		else $error("direction low during EPP read");
	wr_ind_a: assert property ((epp_act && !is_rd_q) |=>
		!write_indicator_out)
		else $error("write indicator high during EPP write");
	rle_last_a: assert property (rle_last_s |=> rs_q == R_ACK)
		else $error("run-length repeat did not finish");
	rdata_follow_a: assert property ((epp_act && is_rd_q) |=>
		host_data_out == $past(pdat_s))
		else $error("EPP read byte not shown to host");
endmodule

// ==== hw/eppp_sync.sv ====
// Two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module eppp_sync #(
	parameter int W = 8,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	// First stage feeds only the second
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			meta_q <= RST;
			q <= RST;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

// ==== testbench/eppp_periph.sv ====
// Peripheral model facing the parallel pins of the port
`timescale 1ns/1ps
module eppp_periph (
	input wire logic clock,
	input wire logic [7:0] dev_pd,
	input wire logic data_strobe_out,
	input wire logic address_strobe_out,
	input wire logic write_indicator_out,
	input wire logic port_direction_out,
	output logic [7:0] periph_drive,
	output logic peripheral_wait_in,
	output logic peripheral_interrupt_in
);
	logic epp_on = 1'b0;
	logic stuck = 1'b0;
	logic fwd_on = 1'b0;
	logic busy = 1'b0;
	logic [7:0] rd_byte = 8'h00;
	logic saw_dir, saw_wr, saw_ds, saw_as;
	logic [7:0] saw_pd;
	logic tags[$];
	int n_late = 0;
	int cnt = 0;
	logic [7:0] got[$];
	wire logic strobe_n = data_strobe_out & address_strobe_out;

	// Idle: wait low means ready for the next transfer
	initial begin
		periph_drive = 8'h00;
		peripheral_wait_in = 1'b0;
		peripheral_interrupt_in = 1'b1;
	end

	// EPP reads answer late on purpose; the sink holds busy to stall the FIFO
	always @(posedge clock) begin
		if (epp_on && !busy && !strobe_n) begin
			busy <= 1'b1;
			cnt <= 0;
			saw_dir <= port_direction_out;
			saw_wr <= write_indicator_out;
			saw_ds <= data_strobe_out;
			saw_as <= address_strobe_out;
			saw_pd <= dev_pd;
		end else if (epp_on && busy && strobe_n) begin
			busy <= 1'b0;
			periph_drive <= ~periph_drive;
			peripheral_wait_in <= 1'b0;
		end else if (epp_on && busy) begin
			cnt <= cnt + 1;
			if (cnt == 3)
				periph_drive <= rd_byte;
			if (cnt == 6 && !stuck)
				peripheral_wait_in <= 1'b1;
		end else if (fwd_on && !busy && !write_indicator_out) begin
			got.push_back(dev_pd);
			tags.push_back(data_strobe_out);
			peripheral_wait_in <= 1'b1;
			busy <= 1'b1;
			cnt <= 0;
		end else if (fwd_on && busy) begin
			cnt <= cnt + 1;
			if (cnt >= 8 && write_indicator_out) begin
				peripheral_wait_in <= 1'b0;
				busy <= 1'b0;
			end
		end
	end

	// Reverse byte; busy low marks a command byte, bus dropped after ack
	task automatic send(input logic [7:0] b, input logic cmd);
		int i;
		@(posedge clock);
		periph_drive <= b;
		peripheral_wait_in <= ~cmd;
		@(posedge clock);
		peripheral_interrupt_in <= 1'b0;
		for (i = 0; i < 40 && !data_strobe_out; i++)
			@(posedge clock);
		// A missed handshake is counted for the bench to report
		if (i == 40)
			n_late++;
		peripheral_interrupt_in <= 1'b1;
		for (i = 0; i < 40 && data_strobe_out; i++)
			@(posedge clock);
		if (i == 40)
			n_late++;
		periph_drive <= ~b;
	endtask
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the multi-mode parallel port
`timescale 1ns/1ps
module tb_top;
	import eppp_pkg::*;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic [10:0] host_addr = 11'h000;
	logic host_rd_n = 1'b1;
	logic host_wr_n = 1'b1;
	logic [7:0] host_data_in = 8'h00;
	logic [2:0] irq_sel = 3'h5;
	logic [2:0] dma_sel = 3'h3;
	logic [7:0] host_data_out, peripheral_data_out, periph_drive, rv;
	logic host_ready, peripheral_data_oe, port_direction_out;
	logic write_indicator_out, data_strobe_out, address_strobe_out;
	logic peripheral_reset_out, irq_out, peripheral_wait_in;
	logic peripheral_interrupt_in, stretched, host_data_oe, dma_req, oe;
	logic [2:0] ml[7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
	int n_mismatch = 0;
	int samples_checked = 0;
	int nw, k;
	// Pin level: the port wins while it drives, else the peripheral
	wire logic [7:0] peripheral_data_bus = peripheral_data_oe ? peripheral_data_out :
		periph_drive;

	eppp_port dut_u (
		.clock, .nrst, .host_addr, .host_aen(1'b0), .host_rd_n, .host_wr_n,
		.dma_ack_n(1'b1), .host_data_in, .host_data_out, .host_data_oe,
		.host_ready, .dma_req, .cfg_irq_sel(irq_sel),
		.cfg_dma_sel(dma_sel), .peripheral_data_in(peripheral_data_bus),
		.peripheral_data_out, .peripheral_data_oe, .port_direction_out,
		.write_indicator_out, .data_strobe_out, .address_strobe_out,
		.peripheral_reset_out, .peripheral_wait_in, .peripheral_interrupt_in,
		.paper_end_in(1'b0), .select_in(1'b1), .fault_n_in(1'b1), .irq_out
	);
	eppp_periph pm_u (
		.clock, .dev_pd(peripheral_data_out), .data_strobe_out,
		.address_strobe_out, .write_indicator_out, .port_direction_out,
		.periph_drive, .peripheral_wait_in, .peripheral_interrupt_in
	);

	// 200 MHz clock
	always #2.5 clock = ~clock;

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask

	task automatic give_verdict();
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// One ISA cycle; idle gap of 6 clocks covers the synchroniser and edge
	// detect, so back-to-back calls never merge two strobes
	task automatic acc(input logic [10:0] a, input logic w,
		input logic [7:0] d);
		int i;
		@(posedge clock);
		host_addr <= a;
		host_data_in <= d;
		// Address settles a clock before the strobe falls
		@(posedge clock);
		host_wr_n <= ~w;
		host_rd_n <= w;
		// Ready can only fall four clocks after the strobe pin
		repeat (5) @(negedge clock);
		stretched = 1'b0;
		for (i = 0; i < 3000 && host_ready !== 1'b1; i++) begin
			stretched = 1'b1;
			@(negedge clock);
		end
		nw = i;
		rv = host_data_out;
		oe = host_data_oe;
		if (i == 3000) begin
			n_mismatch++;
			give_verdict();
		end
		@(posedge clock);
		host_wr_n <= 1'b1;
		host_rd_n <= 1'b1;
		repeat (6) @(posedge clock);
	endtask

	task automatic rchk(input logic [10:0] a, input logic [7:0] m,
		input logic [7:0] e);
		acc(a, 1'b0, 8'h00);
		chk(rv & m, e);
		chk({7'h00, oe}, 8'h01);
	endtask

	task automatic mode(input logic [2:0] m);
		acc(OFF_ECR, 1'b1, {m, 5'h00});
	endtask

	// Main sequence
	initial begin
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		repeat (4) @(posedge clock);
		chk({7'h00, peripheral_reset_out}, 8'h01);
		rchk(OFF_DCR, 8'hff, DCR_RST);
		acc(OFF_DCR, 1'b1, 8'h00);
		chk({7'h00, peripheral_reset_out}, 8'h00);
		// Control and mode read back in every mode
		for (k = 0; k < 7; k++) begin
			mode(ml[k]);
			acc(OFF_DCR, 1'b1, {4'h0, ml[k][0], 3'h4});
			rchk(OFF_DCR, 8'hff, {4'h0, ml[k][0], 3'h4});
			rchk(OFF_ECR, 8'he0, {ml[k], 5'h00});
		end
		rchk(OFF_FIFO, 8'hff, CFGA_VAL);
		rchk(OFF_CFGB, 8'hbf, 8'h2b);
		irq_sel <= 3'h2;
		dma_sel <= 3'h6;
		rchk(OFF_CFGB, 8'hbf, 8'h16);
		// Interrupt pin passes through uninverted once enabled
		mode(MODE_SPP);
		pm_u.peripheral_interrupt_in <= 1'b0;
		acc(OFF_DCR, 1'b1, 8'h14);
		chk({7'h00, irq_out}, 8'h00);
		pm_u.peripheral_interrupt_in <= 1'b1;
		repeat (8) @(posedge clock);
		chk({7'h00, irq_out}, 8'h01);
		// Fill the shared FIFO to full, then drain it in order
		acc(OFF_DCR, 1'b1, 8'h04);
		mode(MODE_TEST);
		for (k = 0; k < 16; k++)
			acc(OFF_FIFO, 1'b1, 8'(k * 37));
		rchk(OFF_ECR, 8'h03, 8'h02);
		for (k = 0; k < 16; k++)
			rchk(OFF_FIFO, 8'hff, 8'(k * 37));
		rchk(OFF_ECR, 8'h03, 8'h01);
		// Compat FIFO strobes bytes out while the peripheral stalls
		mode(MODE_COMPAT_DATA_FIFO);
		pm_u.fwd_on <= 1'b1;
		for (k = 0; k < 3; k++)
			acc(OFF_FIFO, 1'b1, 8'(8'hc1 + k));
		repeat (150) @(posedge clock);
		// Address FIFO bytes go out with the data strobe low
		mode(MODE_ECP);
		acc(OFF_DATA, 1'b1, 8'h11);
		acc(OFF_FIFO, 1'b1, 8'h22);
		repeat (60) @(posedge clock);
		chk(8'(pm_u.got.size()), 8'h05);
		for (k = 0; k < 3; k++)
			chk(pm_u.got[k], 8'(8'hc1 + k));
		chk(pm_u.got[3], 8'h11);
		chk(pm_u.got[4], 8'h22);
		chk({6'h00, pm_u.tags[3], pm_u.tags[4]}, 8'h01);
		pm_u.fwd_on <= 1'b0;
		// EPP data and address reads with a slow peripheral
		mode(MODE_SPP);
		acc(OFF_DCR, 1'b1, 8'h24);
		mode(MODE_EPP);
		pm_u.epp_on <= 1'b1;
		pm_u.rd_byte <= 8'ha6;
		rchk(OFF_EPPD, 8'hff, 8'ha6);
		chk({7'h00, stretched && nw < 30}, 8'h01);
		chk({4'h0, pm_u.saw_dir, pm_u.saw_wr, pm_u.saw_ds,
			pm_u.saw_as}, 8'h0d);
		chk({6'h00, data_strobe_out, address_strobe_out}, 8'h03);
		pm_u.rd_byte <= 8'h3c;
		acc(OFF_DCR, 1'b1, 8'h04);
		rchk(OFF_EPPA, 8'hff, 8'h3c);
		chk({4'h0, pm_u.saw_dir, pm_u.saw_wr, pm_u.saw_ds,
			pm_u.saw_as}, 8'h0e);
		// EPP write: byte on the bus with the write indicator low
		acc(OFF_EPPD, 1'b1, 8'h96);
		chk({4'h0, pm_u.saw_dir, pm_u.saw_wr, pm_u.saw_ds,
			pm_u.saw_as}, 8'h01);
		chk(pm_u.saw_pd, 8'h96);
		// Peripheral never releases wait: watchdog must end the cycle
		pm_u.stuck <= 1'b1;
		acc(OFF_EPPD, 1'b0, 8'h00);
		chk({7'h00, nw >= 1990 && nw <= 2010}, 8'h01);
		pm_u.stuck <= 1'b0;
		rchk(OFF_DSR, 8'h01, 8'h01);
		rchk(OFF_DSR, 8'h01, 8'h00);
		// Reverse run-length: count 2 gives three copies of the next byte
		pm_u.epp_on <= 1'b0;
		mode(MODE_SPP);
		acc(OFF_DCR, 1'b1, 8'h24);
		mode(MODE_ECP);
		pm_u.send(8'h02, 1'b1);
		pm_u.send(8'h5a, 1'b0);
		pm_u.send(8'hc3, 1'b0);
		acc(OFF_ECR, 1'b1, {MODE_ECP, 5'h08});
		chk({7'h00, dma_req}, 8'h01);
		for (k = 0; k < 4; k++)
			rchk(OFF_FIFO, 8'hff, k < 3 ? 8'h5a : 8'hc3);
		rchk(OFF_ECR, 8'h01, 8'h01);
		chk({7'h00, dma_req}, 8'h00);
		chk(8'(pm_u.n_late), 8'h00);
		give_verdict();
	end
endmodule
